//--- common/freq_pull_consts.svh
`ifndef FREQ_PULL_CONSTS_SVH
`define FREQ_PULL_CONSTS_SVH

// device register indices
`define REG_OFFSET_LOW       8'h00
`define REG_OFFSET_HIGH      8'h01
`define REG_PULL_SPAN        8'h02

// device field layout
`define OFFSET_WIDTH         26
`define OFFSET_HIGH_MSB      9
`define OE_BIT               10
`define SPAN_MSB             3
`define OFFSET_RESET         26'h000_0000
`define OFFSET_NEG_LIMIT     26'h200_0000
`define OFFSET_NEG_CLAMP     26'h200_0001
`define SPAN_FACTORY         4'h0

// update rate limit
`define CLK_HZ               20000000
`define UPDATE_RATE_HZ       38000
`define UPDATE_CYCLES        ((`CLK_HZ + `UPDATE_RATE_HZ - 1) / `UPDATE_RATE_HZ)

// controller register byte offsets
`define CTL_OFFSET_WORD      8'h00
`define CTL_CONTROL          8'h04
`define CTL_COMMAND          8'h08
`define CTL_STATUS           8'h0C

// controller field layout
`define CTL_OE_BIT           0
`define CTL_SPAN_LSB         4
`define CMD_SEND_OFFSET      0
`define CMD_SEND_SPAN        1
`define CMD_READ             2
`define CMD_READ_ADDR_LSB    8
`define STAT_BUSY            0
`define STAT_RDATA_LSB       16

`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

//--- common/freq_pull_pkg.sv
`default_nettype none

package freq_pull_pkg;

	typedef logic signed [25:0] offset_word_t;
	typedef logic [3:0]         span_sel_t;
	typedef logic [15:0]        reg_word_t;
	typedef logic [7:0]         reg_addr_t;

	// gray codes along idle -> span -> low -> high -> holdoff
	typedef enum logic [2:0] {
		CTL_IDLE    = 3'b000,
		CTL_SPAN    = 3'b001,
		CTL_LOW     = 3'b011,
		CTL_HIGH    = 3'b010,
		CTL_HOLDOFF = 3'b110,
		CTL_READ    = 3'b100
	} ctl_state_t;

endpackage : freq_pull_pkg

`default_nettype wire

//--- common/freq_pull_if.sv
`default_nettype none

interface freq_pull_if;
	logic                      req;
	logic                      write;
	freq_pull_pkg::reg_addr_t  addr;
	freq_pull_pkg::reg_word_t  wrData;
	freq_pull_pkg::reg_word_t  rdData;
	logic                      ack;

	modport device (
		input  req,
		input  write,
		input  addr,
		input  wrData,
		output rdData,
		output ack
	);

	modport host (
		output req,
		output write,
		output addr,
		output wrData,
		input  rdData,
		input  ack
	);
endinterface : freq_pull_if

`default_nettype wire

//--- hdl/freq_pull_device.sv
// Functional notes
// - power up nominal, factory pull span
// - applied offset kept inside selected span
// - four-bit field selects sixteen spans
// - step size follows selected span
// - offset is 26-bit two's complement
// - offset resets to zero, no shift
// - low half at 0, high at 1
// - host writes low half before high
// - only high half write starts change
// - host scales word to half span
// - host sets enable bit with high half
// - enable bit acts only under software control
// - updates applied at most 38 kHz
// - span, offset, enable all writable
// - enable bit clear disables, set enables
// - unused bits read zero, writes ignored
`include "freq_pull_consts.svh"
`default_nettype none

module freq_pull_device #(
	parameter logic [3:0]  FACTORY_SPAN = `SPAN_FACTORY,
	parameter bit          OE_SOFTWARE  = 1'b1,
	// half span in hundredths of ppm, ascending width
	parameter logic [18:0] SPAN_TABLE [16] = '{
		19'd625,   19'd1000,  19'd1250,   19'd2500,
		19'd5000,  19'd8000,  19'd10000,  19'd12500,
		19'd15000, 19'd20000, 19'd40000,  19'd60000,
		19'd80000, 19'd120000, 19'd160000, 19'd320000},
	// step size in units of 1e-13
	parameter logic [9:0]  STEP_TABLE [16] = '{
		10'd50,  10'd50,  10'd50,  10'd50,
		10'd50,  10'd50,  10'd50,  10'd50,
		10'd50,  10'd50,  10'd100, 10'd140,
		10'd210, 10'd320, 10'd470, 10'd940}
) (
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         resetn,
	// register port
	freq_pull_if.device                       bus,
	// output enable pin, used under hardware control
	input  wire logic                         hwOePin,
	// oscillator control
	output freq_pull_pkg::offset_word_t       appliedOffset,
	output freq_pull_pkg::span_sel_t          appliedSpan,
	output logic [18:0]                       spanHalfWidth,
	output logic [9:0]                        stepSize,
	output logic                              outputEnable,
	output logic                              updateStrobe,
	output logic                              updatePending
);

	localparam logic [9:0] UPDATE_GAP = 10'(`UPDATE_CYCLES);

	freq_pull_pkg::reg_word_t    lowHalf_q;
	logic [`OFFSET_HIGH_MSB:0]   highHalf_q;
	logic                        oeBit_q;
	freq_pull_pkg::span_sel_t    span_q;
	freq_pull_pkg::offset_word_t staged_q;
	logic                        pending_q;
	freq_pull_pkg::offset_word_t applied_q;
	logic [9:0]                  gapCnt_q;
	logic                        strobe_q;
	logic                        ack_q;
	freq_pull_pkg::reg_word_t    rdData_q;
	logic [18:0]                 spanWidth_q;
	logic [9:0]                  step_q;
	logic                        oe_q;

	logic                        take;
	logic                        wrLow;
	logic                        wrHigh;
	logic                        wrSpan;
	logic                        applyNow;

	// the most negative code reaches past the span edge
	function automatic freq_pull_pkg::offset_word_t clampWord(
		input freq_pull_pkg::offset_word_t w
	);
		if (w == `OFFSET_NEG_LIMIT) begin
			clampWord = `OFFSET_NEG_CLAMP;
		end else begin
			clampWord = w;
		end
	endfunction : clampWord

	// one access per request; ack drops for a cycle between two
	assign take     = bus.req && !ack_q;
	assign wrLow    = take && bus.write && (bus.addr == `REG_OFFSET_LOW);
	assign wrHigh   = take && bus.write && (bus.addr == `REG_OFFSET_HIGH);
	assign wrSpan   = take && bus.write && (bus.addr == `REG_PULL_SPAN);
	assign applyNow = pending_q && (gapCnt_q == 10'h000);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= take;
		end
	end

	// register file
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lowHalf_q  <= 16'h0000;
			highHalf_q <= 10'h000;
			oeBit_q    <= 1'b0;
			span_q     <= 4'h0;
		end else begin
			if (wrLow) begin
				lowHalf_q <= bus.wrData;
			end
			if (wrHigh) begin
				highHalf_q <= bus.wrData[`OFFSET_HIGH_MSB:0];
				if (OE_SOFTWARE) begin
					oeBit_q <= bus.wrData[`OE_BIT];
				end
			end
			if (wrSpan) begin
				span_q <= bus.wrData[`SPAN_MSB:0];
			end
		end
	end

	// factory span applies from reset until the first span register write
	logic spanLoaded_q;
	freq_pull_pkg::span_sel_t activeSpan;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			spanLoaded_q <= 1'b0;
		end else if (wrSpan) begin
			spanLoaded_q <= 1'b1;
		end
	end

	assign activeSpan = spanLoaded_q ? span_q : FACTORY_SPAN;

	// readback; unused upper bits are zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdData_q <= 16'h0000;
		end else if (take && !bus.write) begin
			case (bus.addr)
				`REG_OFFSET_LOW:  rdData_q <= lowHalf_q;
				`REG_OFFSET_HIGH: rdData_q <= {5'h00, oeBit_q, highHalf_q};
				`REG_PULL_SPAN:   rdData_q <= {12'h000, activeSpan};
				default:          rdData_q <= 16'h0000;
			endcase
		end
	end

	// snapshot on the high half write; low alone changes nothing
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			staged_q  <= `OFFSET_RESET;
			pending_q <= 1'b0;
		end else begin
			if (wrHigh) begin
				staged_q  <= {bus.wrData[`OFFSET_HIGH_MSB:0], lowHalf_q};
				pending_q <= 1'b1;
			end else if (applyNow) begin
				pending_q <= 1'b0;
			end
		end
	end

	// gap counter keeps updates at or below the rate limit
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gapCnt_q <= 10'h000;
		end else if (applyNow) begin
			gapCnt_q <= UPDATE_GAP - 10'h001;
		end else if (gapCnt_q != 10'h000) begin
			gapCnt_q <= gapCnt_q - 10'h001;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			applied_q <= `OFFSET_RESET;
			strobe_q  <= 1'b0;
		end else begin
			strobe_q <= applyNow;
			if (applyNow) begin
				applied_q <= clampWord(staged_q);
			end
		end
	end

	// span tables and enable follow the live selection
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			spanWidth_q <= 19'h0_0000;
			step_q      <= 10'h000;
			oe_q        <= 1'b0;
		end else begin
			spanWidth_q <= SPAN_TABLE[activeSpan];
			step_q      <= STEP_TABLE[activeSpan];
			oe_q        <= OE_SOFTWARE ? oeBit_q : hwOePin;
		end
	end

	assign bus.ack       = ack_q;
	assign bus.rdData    = rdData_q;
	assign appliedOffset = applied_q;
	assign appliedSpan   = activeSpan;
	assign spanHalfWidth = spanWidth_q;
	assign stepSize      = step_q;
	assign outputEnable  = oe_q;
	assign updateStrobe  = strobe_q;
	assign updatePending = pending_q;

endmodule : freq_pull_device

`default_nettype wire

//--- hdl/freq_pull_host.sv
`include "freq_pull_consts.svh"
`default_nettype none

module freq_pull_host (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// software register port
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	// device side
	freq_pull_if.host         dev
);

	localparam logic [9:0] UPDATE_GAP = 10'(`UPDATE_CYCLES);

	function automatic logic [31:0] mergeBytes(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0]  strb
	);
		for (int i = 0; i < 4; i++) begin
			mergeBytes[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : mergeBytes

	logic                       awTaken_q;
	logic                       wTaken_q;
	logic [7:0]                 awAddr_q;
	logic [31:0]                wData_q;
	logic [3:0]                 wStrb_q;
	logic                       bvalid_q;
	logic [1:0]                 bresp_q;
	logic                       rvalid_q;
	logic [31:0]                rdata_q;
	logic [1:0]                 rresp_q;
	logic [25:0]                word_q;
	logic                       oe_q;
	freq_pull_pkg::span_sel_t   span_q;
	freq_pull_pkg::ctl_state_t  state_q;
	logic                       offPend_q;
	logic [9:0]                 hold_q;
	logic                       req_q;
	logic                       write_q;
	freq_pull_pkg::reg_addr_t   addr_q;
	freq_pull_pkg::reg_word_t   wr_q;
	freq_pull_pkg::reg_word_t   lastRead_q;
	logic                       doWrite;
	logic                       goCmd;
	logic [31:0]                cmdBits;

	assign s_axi_awready = !awTaken_q && !bvalid_q;
	assign s_axi_wready  = !wTaken_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign doWrite       = awTaken_q && wTaken_q && !bvalid_q;
	assign cmdBits       = mergeBytes(32'h0000_0000, wData_q, wStrb_q);
	// commands while busy are dropped
	assign goCmd         = doWrite && (awAddr_q == `CTL_COMMAND) && (state_q == freq_pull_pkg::CTL_IDLE);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			awTaken_q <= 1'b0;
			wTaken_q  <= 1'b0;
			awAddr_q  <= 8'h00;
			wData_q   <= 32'h0000_0000;
			wStrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awTaken_q <= 1'b1;
				awAddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wTaken_q <= 1'b1;
				wData_q  <= s_axi_wdata;
				wStrb_q  <= s_axi_wstrb;
			end
			if (doWrite) begin
				awTaken_q <= 1'b0;
				wTaken_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= (awAddr_q[7:4] == 4'h0 && awAddr_q[1:0] == 2'b00) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			word_q <= 26'h000_0000;
			oe_q   <= 1'b0;
			span_q <= `SPAN_FACTORY;
		end else if (doWrite) begin
			if (awAddr_q == `CTL_OFFSET_WORD) begin
				word_q <= 26'(mergeBytes({6'h00, word_q}, wData_q, wStrb_q));
			end
			if (awAddr_q == `CTL_CONTROL && wStrb_q[0]) begin
				oe_q   <= wData_q[`CTL_OE_BIT];
				span_q <= wData_q[`CTL_SPAN_LSB +: 4];
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rresp_q  <= `RESP_OKAY;
			case (s_axi_araddr)
				`CTL_OFFSET_WORD: rdata_q <= {6'h00, word_q};
				`CTL_CONTROL:     rdata_q <= {24'h00_0000, span_q, 3'h0, oe_q};
				`CTL_COMMAND:     rdata_q <= 32'h0000_0000;
				`CTL_STATUS:      rdata_q <= {lastRead_q, 15'h0000, state_q != freq_pull_pkg::CTL_IDLE};
				default: begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= `RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// sequencer: span, low half, high half, then hold off
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q    <= freq_pull_pkg::CTL_IDLE;
			offPend_q  <= 1'b0;
			hold_q     <= 10'h000;
			req_q      <= 1'b0;
			write_q    <= 1'b0;
			addr_q     <= 8'h00;
			wr_q       <= 16'h0000;
			lastRead_q <= 16'h0000;
		end else begin
			case (state_q)
				freq_pull_pkg::CTL_IDLE: begin
					if (goCmd && cmdBits[`CMD_SEND_SPAN]) begin
						offPend_q <= cmdBits[`CMD_SEND_OFFSET];
						req_q     <= 1'b1;
						write_q   <= 1'b1;
						addr_q    <= `REG_PULL_SPAN;
						wr_q      <= {12'h000, span_q};
						state_q   <= freq_pull_pkg::CTL_SPAN;
					end else if (goCmd && cmdBits[`CMD_SEND_OFFSET]) begin
						req_q   <= 1'b1;
						write_q <= 1'b1;
						addr_q  <= `REG_OFFSET_LOW;
						wr_q    <= word_q[15:0];
						state_q <= freq_pull_pkg::CTL_LOW;
					end else if (goCmd && cmdBits[`CMD_READ]) begin
						req_q   <= 1'b1;
						write_q <= 1'b0;
						addr_q  <= {6'h00, cmdBits[`CMD_READ_ADDR_LSB +: 2]};
						state_q <= freq_pull_pkg::CTL_READ;
					end
				end
				freq_pull_pkg::CTL_SPAN: begin
					if (dev.ack) begin
						if (offPend_q) begin
							addr_q  <= `REG_OFFSET_LOW;
							wr_q    <= word_q[15:0];
							state_q <= freq_pull_pkg::CTL_LOW;
						end else begin
							req_q   <= 1'b0;
							state_q <= freq_pull_pkg::CTL_IDLE;
						end
					end
				end
				freq_pull_pkg::CTL_LOW: begin
					if (dev.ack) begin
						addr_q  <= `REG_OFFSET_HIGH;
						wr_q    <= {5'h00, oe_q, word_q[25:16]};
						state_q <= freq_pull_pkg::CTL_HIGH;
					end
				end
				freq_pull_pkg::CTL_HIGH: begin
					if (dev.ack) begin
						req_q     <= 1'b0;
						offPend_q <= 1'b0;
						hold_q    <= UPDATE_GAP - 10'h001;
						state_q   <= freq_pull_pkg::CTL_HOLDOFF;
					end
				end
				freq_pull_pkg::CTL_HOLDOFF: begin
					if (hold_q == 10'h000) begin
						state_q <= freq_pull_pkg::CTL_IDLE;
					end else begin
						hold_q <= hold_q - 10'h001;
					end
				end
				freq_pull_pkg::CTL_READ: begin
					if (dev.ack) begin
						req_q      <= 1'b0;
						lastRead_q <= dev.rdData;
						state_q    <= freq_pull_pkg::CTL_IDLE;
					end
				end
				default: begin
					req_q   <= 1'b0;
					state_q <= freq_pull_pkg::CTL_IDLE;
				end
			endcase
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;
	assign dev.req      = req_q;
	assign dev.write    = write_q;
	assign dev.addr     = addr_q;
	assign dev.wrData   = wr_q;

endmodule : freq_pull_host

`default_nettype wire

//--- dv/freq_pull_checker_sva.sv
`include "freq_pull_consts.svh"
`default_nettype none

module freq_pull_checker (
	// clock and reset
	input wire logic                        clk,
	input wire logic                        resetn,
	// device link
	input wire logic                        req,
	input wire logic                        write,
	input wire freq_pull_pkg::reg_addr_t    addr,
	input wire freq_pull_pkg::reg_word_t    wrData,
	input wire freq_pull_pkg::reg_word_t    rdData,
	input wire logic                        ack,
	// oscillator control
	input wire freq_pull_pkg::offset_word_t appliedOffset,
	input wire freq_pull_pkg::span_sel_t    appliedSpan,
	input wire logic                        outputEnable,
	input wire logic                        updateStrobe,
	input wire logic                        updatePending
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [11:0] gapCnt_q;
	logic        lowSeen_q;
	logic        oeIn;
	logic [3:0]  spanIn;

	assign oeIn = wrData[`OE_BIT];
	assign spanIn = wrData[3:0];

	// saturates so the first strobe after reset is never judged
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gapCnt_q <= 12'hFFF;
		end else if (updateStrobe) begin
			gapCnt_q <= 12'h000;
		end else if (gapCnt_q != 12'hFFF) begin
			gapCnt_q <= gapCnt_q + 12'h001;
		end
	end

	// a taken low half arms the next high half
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lowSeen_q <= 1'b0;
		end else if (req && !ack && write && addr == `REG_OFFSET_LOW) begin
			lowSeen_q <= 1'b1;
		end else if (req && !ack && write && addr == `REG_OFFSET_HIGH) begin
			lowSeen_q <= 1'b0;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_ackAfterTake; req && !ack |=> ack; endproperty
	a_ackAfterTake: assert property (p_ackAfterTake) else $error("no ack after request");
	property p_ackPulse; ack |=> !ack; endproperty
	a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");
	property p_highUnused; ack && !$past(write) && $past(addr) == 8'h01 |-> rdData[15:11] == 5'h00; endproperty
	a_highUnused: assert property (p_highUnused) else $error("high half unused bits set");
	property p_spanUnused; ack && !$past(write) && $past(addr) == 8'h02 |-> rdData[15:4] == 12'h000; endproperty
	a_spanUnused: assert property (p_spanUnused) else $error("span unused bits set");
	property p_unmapped; ack && !$past(write) && $past(addr) > 8'h02 |-> rdData == 16'h0000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped index reads nonzero");
	// enable register trails the bit by one cycle
	property p_oeWrite; ack && $past(write) && $past(addr) == 8'h01 |=> outputEnable == $past(oeIn, 2); endproperty
	a_oeWrite: assert property (p_oeWrite) else $error("enable bit not applied");
	property p_spanWrite; ack && $past(write) && $past(addr) == 8'h02 |-> appliedSpan == $past(spanIn); endproperty
	a_spanWrite: assert property (p_spanWrite) else $error("span not applied");
	property p_applyNeedsHigh; $changed(appliedOffset) |-> $past(updatePending); endproperty
	a_applyNeedsHigh: assert property (p_applyNeedsHigh) else $error("offset changed without high half");
	property p_strobeFollows; $changed(appliedOffset) |-> updateStrobe; endproperty
	a_strobeFollows: assert property (p_strobeFollows) else $error("no strobe after apply");
	property p_rateGap; updateStrobe |-> gapCnt_q >= 12'd526; endproperty
	a_rateGap: assert property (p_rateGap) else $error("updates too close");
	property p_inSpan; appliedOffset != `OFFSET_NEG_LIMIT; endproperty
	a_inSpan: assert property (p_inSpan) else $error("offset beyond span");
	property p_resetState; $rose(resetn) |-> appliedOffset == 26'h000_0000 && !outputEnable && appliedSpan == 4'h0; endproperty
	a_resetState: assert property (p_resetState) else $error("bad power-up state");
	property p_lowBeforeHigh; req && !ack && write && addr == 8'h01 |-> lowSeen_q; endproperty
	a_lowBeforeHigh: assert property (p_lowBeforeHigh) else $error("high half sent without low half");

	c_update: cover property (updateStrobe);
	c_spanWrite: cover property (ack && $past(write) && $past(addr) == 8'h02);
	c_unmappedRead: cover property (ack && !$past(write) && $past(addr) == 8'h03);
endmodule : freq_pull_checker

`default_nettype wire

//--- dv/test_digital_freq_pull_control.sv
`include "freq_pull_consts.svh"
`default_nettype none

module test_digital_freq_pull_control;
	timeunit 1ns;
	timeprecision 1ns;

	logic                        clk;
	logic                        resetn;
	logic [7:0]                  s_axi_awaddr, s_axi_araddr;
	logic [31:0]                 s_axi_wdata, s_axi_rdata;
	logic [3:0]                  s_axi_wstrb;
	logic [1:0]                  s_axi_bresp, s_axi_rresp;
	logic                        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic                        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic                        s_axi_rvalid, s_axi_rready;
	logic                        hwOePin, outputEnable, updateStrobe, updatePending;
	freq_pull_pkg::offset_word_t appliedOffset;
	freq_pull_pkg::span_sel_t    appliedSpan;
	logic [18:0]                 spanHalfWidth;
	logic [9:0]                  stepSize;
	int                          errCount, checkCount, i;
	logic [31:0]                 lfsr, rd, v, e;
	logic [1:0]                  resp;
	int                          stepExp [16] = '{50, 50, 50, 50, 50, 50, 50, 50, 50, 50, 100, 140, 210, 320, 470, 940};
	int                          vals [$] = '{33554431, 33554432, 15099494, 58720256};

	freq_pull_if link();

	freq_pull_host i_freq_pull_host (.clk(clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .dev(link.host));

	freq_pull_device i_freq_pull_device (.clk(clk), .resetn(resetn), .bus(link.device), .hwOePin(hwOePin),
		.appliedOffset(appliedOffset), .appliedSpan(appliedSpan), .spanHalfWidth(spanHalfWidth),
		.stepSize(stepSize), .outputEnable(outputEnable), .updateStrobe(updateStrobe),
		.updatePending(updatePending));

	freq_pull_checker i_freq_pull_checker (.clk(clk), .resetn(resetn), .req(link.req), .write(link.write),
		.addr(link.addr), .wrData(link.wrData), .rdData(link.rdData), .ack(link.ack),
		.appliedOffset(appliedOffset), .appliedSpan(appliedSpan), .outputEnable(outputEnable),
		.updateStrobe(updateStrobe), .updatePending(updatePending));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	function automatic logic [31:0] nextRand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nextRand

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			errCount++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic report_and_stop;
		if (errCount == 0 && checkCount > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop

	// one transfer; ready is judged at the falling edge, where it already holds its value for the next rise
	task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
		bit aw, w, ar, done;
		int n;
		@(posedge clk);
		if (wr) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end
		done = 1'b0;
		for (n = 0; n < 200 && !done; n++) begin
			@(negedge clk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			ar = s_axi_arvalid && s_axi_arready;
			done = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
			resp = wr ? s_axi_bresp : s_axi_rresp;
			rd = s_axi_rdata;
			@(posedge clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (ar) s_axi_arvalid <= 1'b0;
			if (done) s_axi_bready <= 1'b0;
			if (done) s_axi_rready <= 1'b0;
		end
		if (!done) begin
			errCount++;
			report_and_stop;
		end
	endtask : axi

	task automatic waitIdle;
		int n;
		for (n = 0; n < 1000; n++) begin
			axi(1'b0, `CTL_STATUS, 32'h0000_0000);
			if (rd[`STAT_BUSY] === 1'b0) return;
		end
		errCount++;
		report_and_stop;
	endtask : waitIdle

	task automatic devRead(input logic [1:0] idx);
		axi(1'b1, `CTL_COMMAND, 32'h0000_0004 | {22'h0, idx, 8'h00});
		waitIdle;
	endtask : devRead

	initial begin
		repeat (100000) @(posedge clk);
		errCount++;
		report_and_stop;
	end

	initial begin
		{resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, hwOePin} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		lfsr = 32'h0000_3e05;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		for (i = 0; i < 4; i++) begin
			devRead(i[1:0]);
			chk({16'h0, rd[31:16]}, 32'h0000_0000);
		end
		chk({28'h0, appliedSpan}, 32'h0000_0000);
		chk({31'h0, outputEnable}, 32'h0000_0000);
		axi(1'b1, 8'h10, 32'hFFFF_FFFF);
		chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
		axi(1'b0, 8'h10, 32'h0000_0000);
		chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
		for (i = 0; i < 16; i++) begin
			axi(1'b1, `CTL_CONTROL, 32'(i) << `CTL_SPAN_LSB);
			axi(1'b1, `CTL_COMMAND, 32'h0000_0002);
			waitIdle;
			chk({28'h0, appliedSpan}, 32'(i));
			chk({22'h0, stepSize}, 32'(stepExp[i]));
			devRead(2'd2);
			chk({16'h0, rd[31:16]}, 32'(i));
		end
		chk({13'h0, spanHalfWidth}, 32'd320000);
		// fixed edge words first, then random ones
		for (i = 0; i < 4; i++) begin
			vals.push_back(int'(lfsr[25:0]));
			lfsr = nextRand(lfsr);
		end
		for (i = 0; i < 8; i++) begin
			v = 32'(vals[i]);
			e = (v == 32'h0200_0000) ? 32'h0200_0001 : v;
			// pin must be ignored under software control
			hwOePin <= v[0];
			axi(1'b1, `CTL_OFFSET_WORD, v);
			axi(1'b1, `CTL_CONTROL, 32'h0000_00F0 | 32'(i % 2));
			axi(1'b1, `CTL_COMMAND, 32'h0000_0001);
			waitIdle;
			chk({6'h0, appliedOffset}, e);
			chk({31'h0, updatePending}, 32'h0000_0000);
			chk({31'h0, outputEnable}, 32'(i % 2));
			devRead(2'd0);
			chk({16'h0, rd[31:16]}, {16'h0, v[15:0]});
			devRead(2'd1);
			chk({16'h0, rd[31:16]}, {21'h0, 1'(i % 2), v[25:16]});
		end
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		chk({6'h0, appliedOffset}, 32'h0000_0000);
		chk({28'h0, appliedSpan}, {28'h0, `SPAN_FACTORY});
		chk({31'h0, outputEnable}, 32'h0000_0000);
		report_and_stop;
	end
endmodule : test_digital_freq_pull_control

`default_nettype wire
